// ---- inc/framer_pkg.sv ----
// constants, register map and state types of the packet address and size framer
package framer_pkg;
   localparam logic [5:0] IDX_REMOTE_HI = 6'h38;
   localparam logic [5:0] IDX_REMOTE_LO = 6'h39;
   localparam logic [5:0] IDX_LOCAL_HI = 6'h3A;
   localparam logic [5:0] IDX_LOCAL_LO = 6'h3B;
   localparam logic [5:0] IDX_TX_LEN = 6'h3C;
   localparam logic [5:0] IDX_RX_LEN = 6'h3D;
   localparam logic [5:0] IDX_CFG = 6'h3E;
   localparam logic [5:0] IDX_FIFO = 6'h3F;
   localparam logic [7:0] RST_ADDR = 8'h00;
   localparam logic [7:0] RST_LEN = 8'h10;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam int FILT_LSB = 6;
   localparam int WIDTH_BIT = 5;
   localparam int AHDR_BIT = 4;
   localparam int LHDR_BIT = 3;
   localparam int LSRC_BIT = 2;
   localparam int SADDR_BIT = 1;
   localparam int SLEN_BIT = 0;
   localparam logic [1:0] FILT_NONE = 2'h0;
   localparam logic [1:0] FILT_REJECT = 2'h1;
   localparam logic [1:0] FILT_REPLY = 2'h2;
   localparam logic [1:0] FILT_BOTH = 2'h3;
   localparam int FIFO_DEPTH_DEF = 128;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_ADDR_HI = 3'h1,
      ST_ADDR_LO = 3'h2,
      ST_LEN = 3'h3,
      ST_PAY = 3'h4
   } frame_state_t;
endpackage

// ---- hw/packet_address_size_framer.sv ----
// packet header framer and parser with register file, tx/rx fifos and wishbone slave
//
// Functional notes
// RULE1: the tx framer sends the remote node address as the packet address field.
// RULE2: the 16-bit local node address sits in two byte registers and is compared on receive.
// RULE3: tx_payload_length gives the next tx payload length and resets to 0x10.
// RULE4: rx_payload_length gives the expected rx payload length and resets to 0x10.
// RULE5: address_filter_mode selects none, reject, reply-on-match, or reject-and-cancel.
// RULE6: address_width_select picks a 16-bit address field when one, 8-bit when zero.
// RULE7: address_header_enable adds the address field to transmitted packets.
// RULE8: length_header_enable adds the payload size field to transmitted packets.
// RULE9: length_source_select takes the size from the register, else from the first fifo byte.
// RULE10: store_rx_address writes the received address bytes first into the rx fifo.
// RULE11: store_rx_length writes the received size byte first into the rx fifo.
// RULE12: reading the fifo port pops one byte from the rx fifo.
// RULE13: writing the fifo port pushes one byte into the tx fifo.
// RULE14: the packet configuration register resets to all zero.
// RULE15: with an 8-bit address only the low address bytes are sent and compared.
`timescale 1ns/1ns
module packet_address_size_framer #(
   parameter int FIFO_DEPTH = framer_pkg::FIFO_DEPTH_DEF
)(
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic [7:0] ADR_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   input wire logic WE_I,
   input wire logic [3:0] SEL_I,
   input wire logic STB_I,
   input wire logic CYC_I,
   output logic ACK_O,
   input wire logic TX_START,
   output logic [7:0] TX_DATA,
   output logic TX_VALID,
   input wire logic TX_READY,
   output logic TX_BUSY,
   input wire logic RX_START,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_VALID,
   output logic RX_READY,
   output logic RX_ADDR_MATCH,
   output logic RX_REJECT,
   output logic RX_AUTOREPLY_OK,
   output logic RX_DONE
);
   localparam int AW = $clog2(FIFO_DEPTH);
   typedef logic [AW:0] cnt_t;
   typedef logic [AW-1:0] ptr_t;

   if (FIFO_DEPTH < 2 || (1 << AW) != FIFO_DEPTH)
   begin
      $error("FIFO_DEPTH must be a power of two of at least 2");
   end

   logic [7:0] remote_hi_r, remote_lo_r, local_hi_r, local_lo_r, tx_len_r, rx_len_r, cfg_r;
   logic [7:0] remote_hi_nxt, remote_lo_nxt, local_hi_nxt, local_lo_nxt;
   logic [7:0] tx_len_nxt, rx_len_nxt, cfg_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic [7:0] mem_r [2][FIFO_DEPTH];
   logic [7:0] mem_nxt [2][FIFO_DEPTH];
   ptr_t wr_r [2];
   ptr_t wr_nxt [2];
   ptr_t rd_r [2];
   ptr_t rd_nxt [2];
   cnt_t cnt_r [2];
   cnt_t cnt_nxt [2];
   logic push [2];
   logic pop [2];
   logic [7:0] din [2];
   logic [7:0] head [2];
   logic full [2];
   logic empty [2];

   framer_pkg::frame_state_t tx_st_r, tx_st_nxt, rx_st_r, rx_st_nxt;
   logic [7:0] tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt;
   logic [7:0] tx_data_r, tx_data_nxt, rx_ahi_r, rx_ahi_nxt;
   logic tx_valid_r, tx_valid_nxt, tx_pop, tx_load, tx_push;
   logic rx_push, rx_pop, rx_acc, rx_ready, rx_match;
   logic match_r, match_nxt, rej_r, rej_nxt, auto_r, auto_nxt, rejp_r, rejp_nxt;
   logic done_r, done_nxt;

   wire req = CYC_I & STB_I & ~ack_r;
   wire [5:0] idx = ADR_I[7:2];
   wire bus_wr = req & WE_I & SEL_I[0];
   wire bus_rd = req & ~WE_I;
   wire width16 = cfg_r[framer_pkg::WIDTH_BIT];
   wire [1:0] fmode = cfg_r[framer_pkg::FILT_LSB +: 2];

   // a push to a full fifo and a pop from an empty one are dropped
   assign tx_push = bus_wr & (idx == framer_pkg::IDX_FIFO) & ~full[0]; // RULE13
   assign rx_pop = bus_rd & (idx == framer_pkg::IDX_FIFO) & ~empty[1]; // RULE12
   assign push[0] = tx_push;
   assign din[0] = DAT_I[7:0];
   assign pop[0] = tx_pop;
   assign push[1] = rx_push;
   assign din[1] = RX_DATA;
   assign pop[1] = rx_pop;

   always_comb
   begin
      mem_nxt = mem_r;
      for (int i = 0; i < 2; i++)
      begin
         head[i] = mem_r[i][rd_r[i]];
         full[i] = (cnt_r[i] == cnt_t'(FIFO_DEPTH));
         empty[i] = (cnt_r[i] == '0);
         wr_nxt[i] = wr_r[i];
         rd_nxt[i] = rd_r[i];
         if (push[i])
         begin
            mem_nxt[i][wr_r[i]] = din[i];
            wr_nxt[i] = ptr_t'(wr_r[i] + 1'b1);
         end
         if (pop[i])
            rd_nxt[i] = ptr_t'(rd_r[i] + 1'b1);
         cnt_nxt[i] = cnt_t'(cnt_r[i] + cnt_t'(push[i]) - cnt_t'(pop[i]));
      end
   end

   // register file and wishbone answer, ack one cycle after the strobe
   always_comb
   begin
      remote_hi_nxt = remote_hi_r;
      remote_lo_nxt = remote_lo_r;
      local_hi_nxt = local_hi_r;
      local_lo_nxt = local_lo_r;
      tx_len_nxt = tx_len_r;
      rx_len_nxt = rx_len_r;
      cfg_nxt = cfg_r;
      ack_nxt = req;
      dat_nxt = dat_r;
      if (bus_wr)
      begin
         unique case (idx)
            framer_pkg::IDX_REMOTE_HI: remote_hi_nxt = DAT_I[7:0];
            framer_pkg::IDX_REMOTE_LO: remote_lo_nxt = DAT_I[7:0];
            framer_pkg::IDX_LOCAL_HI: local_hi_nxt = DAT_I[7:0]; // RULE2
            framer_pkg::IDX_LOCAL_LO: local_lo_nxt = DAT_I[7:0]; // RULE2
            framer_pkg::IDX_TX_LEN: tx_len_nxt = DAT_I[7:0];
            framer_pkg::IDX_RX_LEN: rx_len_nxt = DAT_I[7:0];
            framer_pkg::IDX_CFG: cfg_nxt = DAT_I[7:0];
            default: ;
         endcase
      end
      if (bus_rd)
      begin
         dat_nxt = 32'h0000_0000;
         unique case (idx)
            framer_pkg::IDX_REMOTE_HI: dat_nxt[7:0] = remote_hi_r;
            framer_pkg::IDX_REMOTE_LO: dat_nxt[7:0] = remote_lo_r;
            framer_pkg::IDX_LOCAL_HI: dat_nxt[7:0] = local_hi_r;
            framer_pkg::IDX_LOCAL_LO: dat_nxt[7:0] = local_lo_r;
            framer_pkg::IDX_TX_LEN: dat_nxt[7:0] = tx_len_r;
            framer_pkg::IDX_RX_LEN: dat_nxt[7:0] = rx_len_r;
            framer_pkg::IDX_CFG: dat_nxt[7:0] = cfg_r;
            framer_pkg::IDX_FIFO: dat_nxt[7:0] = empty[1] ? 8'h00 : head[1]; // RULE12
            default: ;
         endcase
      end
   end

   // tx framer: address field, size field, then payload from the tx fifo
   assign tx_load = ~tx_valid_r | TX_READY;
   always_comb
   begin
      tx_st_nxt = tx_st_r;
      tx_cnt_nxt = tx_cnt_r;
      tx_data_nxt = tx_data_r;
      tx_valid_nxt = tx_valid_r & ~TX_READY;
      tx_pop = 1'b0;
      unique case (tx_st_r)
         framer_pkg::ST_IDLE:
            if (TX_START)
            begin
               if (cfg_r[framer_pkg::AHDR_BIT]) // RULE7
                  tx_st_nxt = width16 ? framer_pkg::ST_ADDR_HI : framer_pkg::ST_ADDR_LO; // RULE6
               else
                  tx_st_nxt = framer_pkg::ST_LEN;
            end
         framer_pkg::ST_ADDR_HI:
            if (tx_load)
            begin
               tx_data_nxt = remote_hi_r; // RULE1
               tx_valid_nxt = 1'b1;
               tx_st_nxt = framer_pkg::ST_ADDR_LO;
            end
         framer_pkg::ST_ADDR_LO:
            if (tx_load)
            begin
               tx_data_nxt = remote_lo_r; // RULE15
               tx_valid_nxt = 1'b1;
               tx_st_nxt = framer_pkg::ST_LEN;
            end
         framer_pkg::ST_LEN:
            if (tx_load && (cfg_r[framer_pkg::LSRC_BIT] || !empty[0]))
            begin
               tx_pop = ~cfg_r[framer_pkg::LSRC_BIT]; // RULE9
               tx_cnt_nxt = cfg_r[framer_pkg::LSRC_BIT] ? tx_len_r : head[0]; // RULE3
               tx_data_nxt = tx_cnt_nxt;
               tx_valid_nxt = cfg_r[framer_pkg::LHDR_BIT]; // RULE8
               tx_st_nxt = (tx_cnt_nxt == 8'h00) ? framer_pkg::ST_IDLE : framer_pkg::ST_PAY;
            end
         framer_pkg::ST_PAY:
            if (tx_load && !empty[0])
            begin
               tx_pop = 1'b1;
               tx_data_nxt = head[0];
               tx_valid_nxt = 1'b1;
               tx_cnt_nxt = tx_cnt_r - 8'h01;
               if (tx_cnt_r == 8'h01)
                  tx_st_nxt = framer_pkg::ST_IDLE;
            end
         default: tx_st_nxt = framer_pkg::ST_IDLE;
      endcase
   end

   // rx parser: address compare and filter, optional saving of header bytes
   // no byte is taken in the size step when the size header is off
   assign rx_ready = (rx_st_r != framer_pkg::ST_IDLE) & ~full[1] &
                     ~((rx_st_r == framer_pkg::ST_LEN) & ~cfg_r[framer_pkg::LHDR_BIT]);
   assign rx_acc = RX_VALID & rx_ready;
   assign rx_match = (RX_DATA == local_lo_r) & (~width16 | (rx_ahi_r == local_hi_r)); // RULE15
   always_comb
   begin
      rx_st_nxt = rx_st_r;
      rx_cnt_nxt = rx_cnt_r;
      rx_ahi_nxt = rx_ahi_r;
      match_nxt = match_r;
      rej_nxt = rej_r;
      auto_nxt = auto_r;
      rejp_nxt = 1'b0;
      done_nxt = 1'b0;
      rx_push = 1'b0;
      unique case (rx_st_r)
         framer_pkg::ST_IDLE:
            if (RX_START)
            begin
               match_nxt = 1'b1;
               rej_nxt = 1'b0;
               auto_nxt = 1'b1;
               rx_ahi_nxt = 8'h00;
               if (cfg_r[framer_pkg::AHDR_BIT])
                  rx_st_nxt = width16 ? framer_pkg::ST_ADDR_HI : framer_pkg::ST_ADDR_LO;
               else
                  rx_st_nxt = framer_pkg::ST_LEN;
            end
         framer_pkg::ST_ADDR_HI:
            if (rx_acc)
            begin
               rx_ahi_nxt = RX_DATA;
               rx_push = cfg_r[framer_pkg::SADDR_BIT]; // RULE10
               rx_st_nxt = framer_pkg::ST_ADDR_LO;
            end
         framer_pkg::ST_ADDR_LO:
            if (rx_acc)
            begin
               rx_push = cfg_r[framer_pkg::SADDR_BIT]; // RULE10
               match_nxt = rx_match; // RULE2
               rej_nxt = ~rx_match & ((fmode == framer_pkg::FILT_REJECT) |
                                      (fmode == framer_pkg::FILT_BOTH)); // RULE5
               auto_nxt = rx_match | (fmode == framer_pkg::FILT_NONE) |
                          (fmode == framer_pkg::FILT_REJECT); // RULE5
               rejp_nxt = rej_nxt;
               rx_st_nxt = framer_pkg::ST_LEN;
            end
         framer_pkg::ST_LEN:
            if (!cfg_r[framer_pkg::LHDR_BIT])
            begin
               rx_cnt_nxt = rx_len_r; // RULE4
               done_nxt = (rx_len_r == 8'h00);
               rx_st_nxt = done_nxt ? framer_pkg::ST_IDLE : framer_pkg::ST_PAY;
            end
            else if (rx_acc)
            begin
               rx_push = cfg_r[framer_pkg::SLEN_BIT] & ~rej_r; // RULE11
               rx_cnt_nxt = RX_DATA;
               done_nxt = (RX_DATA == 8'h00);
               rx_st_nxt = done_nxt ? framer_pkg::ST_IDLE : framer_pkg::ST_PAY;
            end
         framer_pkg::ST_PAY:
            if (rx_acc)
            begin
               rx_push = ~rej_r; // RULE5
               rx_cnt_nxt = rx_cnt_r - 8'h01;
               if (rx_cnt_r == 8'h01)
               begin
                  done_nxt = 1'b1;
                  rx_st_nxt = framer_pkg::ST_IDLE;
               end
            end
         default: rx_st_nxt = framer_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS)
   begin
      mem_r <= mem_nxt;
      if (RESET)
      begin
         remote_hi_r <= framer_pkg::RST_ADDR;
         remote_lo_r <= framer_pkg::RST_ADDR;
         local_hi_r <= framer_pkg::RST_ADDR;
         local_lo_r <= framer_pkg::RST_ADDR;
         tx_len_r <= framer_pkg::RST_LEN; // RULE3
         rx_len_r <= framer_pkg::RST_LEN; // RULE4
         cfg_r <= framer_pkg::RST_CFG; // RULE14
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
         for (int i = 0; i < 2; i++)
         begin
            wr_r[i] <= '0;
            rd_r[i] <= '0;
            cnt_r[i] <= '0;
         end
         tx_st_r <= framer_pkg::ST_IDLE;
         rx_st_r <= framer_pkg::ST_IDLE;
         tx_cnt_r <= 8'h00;
         rx_cnt_r <= 8'h00;
         tx_data_r <= 8'h00;
         rx_ahi_r <= 8'h00;
         tx_valid_r <= 1'b0;
         match_r <= 1'b0;
         rej_r <= 1'b0;
         auto_r <= 1'b0;
         rejp_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         remote_hi_r <= remote_hi_nxt;
         remote_lo_r <= remote_lo_nxt;
         local_hi_r <= local_hi_nxt;
         local_lo_r <= local_lo_nxt;
         tx_len_r <= tx_len_nxt;
         rx_len_r <= rx_len_nxt;
         cfg_r <= cfg_nxt;
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
         tx_st_r <= tx_st_nxt;
         rx_st_r <= rx_st_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         tx_data_r <= tx_data_nxt;
         rx_ahi_r <= rx_ahi_nxt;
         tx_valid_r <= tx_valid_nxt;
         match_r <= match_nxt;
         rej_r <= rej_nxt;
         auto_r <= auto_nxt;
         rejp_r <= rejp_nxt;
         done_r <= done_nxt;
      end
   end

   assign ACK_O = ack_r;
   assign DAT_O = dat_r;
   assign TX_DATA = tx_data_r;
   assign TX_VALID = tx_valid_r;
   assign TX_BUSY = (tx_st_r != framer_pkg::ST_IDLE) | tx_valid_r;
   assign RX_READY = rx_ready;
   assign RX_ADDR_MATCH = match_r;
   assign RX_REJECT = rejp_r;
   assign RX_AUTOREPLY_OK = auto_r;
   assign RX_DONE = done_r;

   sequence s_fifo_read;
      rx_pop && !rx_push;
   endsequence
   property p_fifo_pop;
      @(posedge CLK_SYS) disable iff (RESET)
      s_fifo_read |=> ack_r && cnt_r[1] == cnt_t'($past(cnt_r[1]) - 1'b1)
         && dat_r[7:0] == $past(head[1]);
   endproperty
   a_fifo_pop: assert property (p_fifo_pop) else $error("rx fifo read did not pop"); // RULE12
   property p_fifo_push;
      @(posedge CLK_SYS) disable iff (RESET)
      tx_push && !tx_pop |=> cnt_r[0] == cnt_t'($past(cnt_r[0]) + 1'b1);
   endproperty
   a_fifo_push: assert property (p_fifo_push) else $error("tx fifo write lost"); // RULE13
   property p_cfg_reset;
      @(posedge CLK_SYS) RESET |=> cfg_r == framer_pkg::RST_CFG && tx_len_r == framer_pkg::RST_LEN
         && rx_len_r == framer_pkg::RST_LEN;
   endproperty
   a_cfg_reset: assert property (p_cfg_reset) else $error("bad reset values"); // RULE14
   property p_tx_addr;
      @(posedge CLK_SYS) disable iff (RESET)
      tx_st_r == framer_pkg::ST_ADDR_LO && tx_load |=> tx_valid_r && tx_data_r == remote_lo_r;
   endproperty
   a_tx_addr: assert property (p_tx_addr) else $error("remote address not sent"); // RULE1
   property p_width8;
      @(posedge CLK_SYS) disable iff (RESET)
      tx_st_r == framer_pkg::ST_IDLE && TX_START && cfg_r[framer_pkg::AHDR_BIT] && !width16
         |=> tx_st_r == framer_pkg::ST_ADDR_LO;
   endproperty
   a_width8: assert property (p_width8) else $error("8-bit address not selected"); // RULE6
   property p_no_ahdr;
      @(posedge CLK_SYS) disable iff (RESET)
      tx_st_r == framer_pkg::ST_IDLE && TX_START && !cfg_r[framer_pkg::AHDR_BIT]
         |=> tx_st_r == framer_pkg::ST_LEN;
   endproperty
   a_no_ahdr: assert property (p_no_ahdr) else $error("address field not omitted"); // RULE7
   property p_len_src;
      @(posedge CLK_SYS) disable iff (RESET)
      tx_st_r == framer_pkg::ST_LEN && tx_load && cfg_r[framer_pkg::LSRC_BIT]
         |=> tx_cnt_r == $past(tx_len_r) && tx_valid_r == $past(cfg_r[framer_pkg::LHDR_BIT]);
   endproperty
   a_len_src: assert property (p_len_src) else $error("size source or header wrong"); // RULE9
   property p_reject;
      @(posedge CLK_SYS) disable iff (RESET)
      rx_st_r == framer_pkg::ST_ADDR_LO && rx_acc && !rx_match && fmode == 2'h1
         |=> RX_REJECT && rej_r && !match_r ##1 !RX_REJECT;
   endproperty
   a_reject: assert property (p_reject) else $error("mismatch not rejected"); // RULE5
   property p_bus_ack;
      @(posedge CLK_SYS) disable iff (RESET)
      req |=> ack_r ##1 !ack_r;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("ack not a single cycle"); // wishbone ack one cycle after the strobe
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the packet address and size framer
`timescale 1ns/1ns
module tb;
   logic CLK_SYS = 1'b0;
   logic RESET = 1'b1;
   logic [7:0] ADR_I = 8'h00;
   logic [31:0] DAT_I = 32'h0000_0000;
   logic [31:0] DAT_O;
   logic WE_I = 1'b0;
   logic [3:0] SEL_I = 4'h0;
   logic STB_I = 1'b0;
   logic CYC_I = 1'b0;
   logic ACK_O;
   logic TX_START = 1'b0;
   logic [7:0] TX_DATA;
   logic TX_VALID;
   logic TX_READY = 1'b0;
   logic TX_BUSY;
   logic RX_START = 1'b0;
   logic [7:0] RX_DATA = 8'h00;
   logic RX_VALID = 1'b0;
   logic RX_READY;
   logic RX_ADDR_MATCH;
   logic RX_REJECT;
   logic RX_AUTOREPLY_OK;
   logic RX_DONE;
   int err_total = 0;
   int checked = 0;
   logic rej_seen = 1'b0;
   logic done_seen = 1'b0;
   logic [7:0] addr_v[4];

   packet_address_size_framer #(.FIFO_DEPTH(16)) uut (
      .CLK_SYS(CLK_SYS), .RESET(RESET), .ADR_I(ADR_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
      .WE_I(WE_I), .SEL_I(SEL_I), .STB_I(STB_I), .CYC_I(CYC_I), .ACK_O(ACK_O),
      .TX_START(TX_START), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
      .TX_BUSY(TX_BUSY), .RX_START(RX_START), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
      .RX_READY(RX_READY), .RX_ADDR_MATCH(RX_ADDR_MATCH), .RX_REJECT(RX_REJECT),
      .RX_AUTOREPLY_OK(RX_AUTOREPLY_OK), .RX_DONE(RX_DONE)
   );

   always #5 CLK_SYS = ~CLK_SYS;

   // rx pulses are one cycle wide, so latch them for the scenario
   always @(posedge CLK_SYS)
   begin
      if (RX_REJECT === 1'b1) rej_seen = 1'b1;
      if (RX_DONE === 1'b1) done_seen = 1'b1;
   end

   task automatic summarize;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   // classic single wishbone cycle, entered just after a rising edge
   task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
      int n;
      n = 0;
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      WE_I <= we;
      SEL_I <= 4'h1;
      ADR_I <= {idx, 2'b00};
      DAT_I <= {24'h00_0000, wd};
      do
      begin
         @(posedge CLK_SYS);
         n++;
      end while (ACK_O !== 1'b1 && n < 50);
      chk1("wb ack", 1'b1, ACK_O);
      rd = DAT_O[7:0];
      CYC_I <= 1'b0;
      STB_I <= 1'b0;
      @(posedge CLK_SYS);
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic [7:0] dummy;
      wb(1'b1, idx, d, dummy);
   endtask

   task automatic rd_chk(input string what, input logic [5:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      wb(1'b0, idx, 8'h00, d);
      chk8(what, exp, d);
   endtask

   function automatic logic [7:0] reset_of(input logic [5:0] idx);
      if (idx == framer_pkg::IDX_TX_LEN || idx == framer_pkg::IDX_RX_LEN)
         return framer_pkg::RST_LEN;
      if (idx == framer_pkg::IDX_CFG)
         return framer_pkg::RST_CFG;
      return framer_pkg::RST_ADDR;
   endfunction

   task automatic tx_case(input logic [7:0] cfg, input logic [7:0] n);
      logic [7:0] e[$];
      logic [7:0] got[$];
      logic [7:0] b;
      int k;
      wr(framer_pkg::IDX_CFG, cfg);
      // with the size taken from the fifo the register holds a decoy value
      wr(framer_pkg::IDX_TX_LEN, cfg[framer_pkg::LSRC_BIT] ? n : n + 8'h01);
      if (cfg[framer_pkg::AHDR_BIT])
      begin
         if (cfg[framer_pkg::WIDTH_BIT]) e.push_back(addr_v[0]);
         e.push_back(addr_v[1]);
      end
      if (cfg[framer_pkg::LHDR_BIT]) e.push_back(n);
      if (!cfg[framer_pkg::LSRC_BIT]) wr(framer_pkg::IDX_FIFO, n);
      for (k = 0; k < int'(n); k++)
      begin
         b = 8'($urandom);
         wr(framer_pkg::IDX_FIFO, b);
         e.push_back(b);
      end
      TX_START <= 1'b1;
      @(posedge CLK_SYS);
      TX_START <= 1'b0;
      k = 0;
      while (got.size() < e.size() && k < 300)
      begin
         @(posedge CLK_SYS);
         k++;
         if (TX_VALID === 1'b1 && TX_READY === 1'b1) got.push_back(TX_DATA);
         TX_READY <= 1'($urandom);
      end
      for (k = 0; k < e.size(); k++) chk8("tx byte", e[k], got[k]);
      k = 0;
      while (TX_BUSY !== 1'b0 && k < 20)
      begin
         @(posedge CLK_SYS);
         k++;
         TX_READY <= 1'b1;
      end
      chk1("tx busy", 1'b0, TX_BUSY);
   endtask

   task automatic rx_case(input logic [7:0] cfg, input logic hit, input logic [7:0] n);
      logic [7:0] pk[$];
      logic [7:0] e[$];
      logic [7:0] b;
      logic m;
      logic rj;
      int k;
      wr(framer_pkg::IDX_CFG, cfg);
      wr(framer_pkg::IDX_RX_LEN, n);
      m = hit | ~cfg[framer_pkg::AHDR_BIT];
      rj = ~m & cfg[framer_pkg::FILT_LSB];
      if (cfg[framer_pkg::AHDR_BIT])
      begin
         if (cfg[framer_pkg::WIDTH_BIT]) pk.push_back(addr_v[2]);
         pk.push_back(hit ? addr_v[3] : ~addr_v[3]);
      end
      // address bytes are stored ahead of the filter decision
      if (cfg[framer_pkg::SADDR_BIT]) e = pk;
      if (cfg[framer_pkg::LHDR_BIT]) pk.push_back(n);
      if (cfg[framer_pkg::LHDR_BIT] && cfg[framer_pkg::SLEN_BIT] && !rj) e.push_back(n);
      for (k = 0; k < int'(n); k++)
      begin
         b = 8'($urandom);
         pk.push_back(b);
         if (!rj) e.push_back(b);
      end
      rej_seen = 1'b0;
      done_seen = 1'b0;
      RX_START <= 1'b1;
      @(posedge CLK_SYS);
      RX_START <= 1'b0;
      foreach (pk[i])
      begin
         RX_VALID <= 1'b1;
         RX_DATA <= pk[i];
         k = 0;
         do
         begin
            @(posedge CLK_SYS);
            k++;
         end while (RX_READY !== 1'b1 && k < 50);
         chk1("rx ready", 1'b1, RX_READY);
      end
      RX_VALID <= 1'b0;
      RX_DATA <= ~RX_DATA;
      k = 0;
      while (done_seen == 1'b0 && k < 8)
      begin
         @(posedge CLK_SYS);
         k++;
      end
      if (!rj) chk1("rx done", 1'b1, done_seen);
      chk1("rx match", m, RX_ADDR_MATCH);
      chk1("rx reject", rj, rej_seen);
      chk1("rx autoreply", m | ~cfg[framer_pkg::FILT_LSB + 1], RX_AUTOREPLY_OK);
      foreach (e[i]) rd_chk("rx fifo", framer_pkg::IDX_FIFO, e[i]);
      rd_chk("rx fifo empty", framer_pkg::IDX_FIFO, 8'h00);
   endtask

   initial
   begin
      repeat (20000) @(posedge CLK_SYS);
      err_total++;
      summarize();
   end

   initial
   begin
      int i;
      void'($urandom(32'h877e));
      repeat (3) @(posedge CLK_SYS);
      RESET <= 1'b0;
      @(posedge CLK_SYS);
      for (i = 8'h38; i <= 8'h3E; i++) rd_chk("reset value", i[5:0], reset_of(i[5:0]));
      rd_chk("unmapped", 6'h10, 8'h00);
      rd_chk("empty rx fifo", framer_pkg::IDX_FIFO, 8'h00);
      for (i = 0; i < 4; i++)
      begin
         addr_v[i] = 8'($urandom) | 8'h01;
         wr(framer_pkg::IDX_REMOTE_HI + 6'(i), addr_v[i]);
      end
      for (i = 0; i < 4; i++) rd_chk("address reg", framer_pkg::IDX_REMOTE_HI + 6'(i), addr_v[i]);
      tx_case(8'h3C, 8'h02);
      tx_case(8'h1C, 8'h01);
      tx_case(8'h18, 8'h00);
      tx_case(8'h08, 8'($urandom_range(1, 4)));
      tx_case(8'h04, 8'h03);
      for (i = 0; i < 8; i++) rx_case({i[1:0], 6'h3B}, i[2], 8'($urandom_range(0, 3)));
      rx_case(8'h58, 1'b1, 8'h02);
      rx_case(8'h00, 1'b0, 8'h01);
      summarize();
   end
endmodule
